// file: design/adc_cal_regs_map.svh
/*
 * Register offsets, field positions, reset values and fixed constants
 * of the channel configuration and calibration register bank.
 * Assumes it is included by bare name from the design files.
 */
`ifndef ADC_CAL_REGS_MAP_SVH
`define ADC_CAL_REGS_MAP_SVH

// ****************************************************************
// Register offsets on the plain register port.
// ****************************************************************
`define CH0_INPUT_CONFIG_ADDR  8'h09
`define CH0_OFFSET_UPPER_ADDR  8'h0A
`define CH0_OFFSET_LOWER_ADDR  8'h0B
`define CH0_GAIN_UPPER_ADDR    8'h0C
`define CH0_GAIN_LOWER_ADDR    8'h0D
`define CH1_INPUT_CONFIG_ADDR  8'h0E
`define CH1_OFFSET_UPPER_ADDR  8'h0F
`define CH1_OFFSET_LOWER_ADDR  8'h10

// ****************************************************************
// Field positions.
// ****************************************************************
`define SEL_MSB                1
`define SEL_LSB                0
`define LOWER_BYTE_MSB         15
`define LOWER_BYTE_LSB         8
`define RSVD_BYTE_MSB          7
`define RSVD_BYTE_LSB          0
`define CFG_RO_MSB             5
`define CFG_RO_LSB             3
`define CFG_KEEP_MASK          16'hFFC4

// ****************************************************************
// Reset values and fixed words.
// ****************************************************************
`define CFG_RESET              16'h0000
`define CAL_UPPER_RESET        16'h0000
`define GAIN_UPPER_RESET       16'h8000
`define CAL_LOWER_RESET        8'h00
`define RSVD_BYTE_VALUE        8'h00
`define READ_IDLE              16'h0000
`define GAIN_UNITY             24'h800000
`define GAIN_FRAC_BITS         23
`define SAT_POS                24'h7FFFFF
`define SAT_NEG                24'h800000

`endif

// file: design/adc_cal_pkg.sv
/*
 * Types shared by the calibration register bank and its submodules.
 * Assumes nothing of its surroundings.
 */
package adc_cal_pkg;

	typedef enum logic [1:0] {
		SEL_PINS     = 2'h0,
		SEL_SHORT    = 2'h1,
		SEL_TEST_POS = 2'h2,
		SEL_TEST_NEG = 2'h3
	} input_sel_t;

	// Converter front-end switch controls for one channel.
	typedef struct packed {
		logic pins_connected;
		logic inputs_shorted;
		logic test_pos;
		logic test_neg;
	} route_t;

	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

	typedef struct packed {
		logic        valid;
		logic [23:0] data;
	} sample_t;

endpackage

// file: design/input_route.sv
/*
 * Decodes one channel's input select field into front-end switch
 * controls, registered.
 * Assumes a synchronous active-high reset on ref_clk.
 */
`timescale 1ns/1ps

module input_route (
	// Clock and reset.
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	// Selection in, switches out.
	input  wire adc_cal_pkg::input_sel_t sel,
	output      adc_cal_pkg::route_t     route
);

	adc_cal_pkg::route_t next_route;

	always_comb begin
		next_route = '0;
		case (sel)
			adc_cal_pkg::SEL_PINS:     next_route.pins_connected = 1'b1;
			adc_cal_pkg::SEL_SHORT:    next_route.inputs_shorted = 1'b1;
			adc_cal_pkg::SEL_TEST_POS: next_route.test_pos = 1'b1;
			adc_cal_pkg::SEL_TEST_NEG: next_route.test_neg = 1'b1;
			default:                   next_route = '0;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			route <= '{pins_connected: 1'b1, default: 1'b0};
		end else begin
			route <= next_route;
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************
	route_short_a: assert property (@(posedge ref_clk) disable iff (rst)
		sel == adc_cal_pkg::SEL_SHORT |=> route.inputs_shorted
			&& !route.pins_connected && !route.test_pos && !route.test_neg)
		else $error("Shorted selection did not open the pins.");

	route_test_a: assert property (@(posedge ref_clk) disable iff (rst)
		sel[1] |=> !route.pins_connected
			&& (route.test_neg == $past(sel[0]))
			&& (route.test_pos == !$past(sel[0])))
		else $error("Test signal polarity does not follow selection.");

endmodule // input_route

// file: design/cal_corrector.sv
/*
 * Applies offset then gain correction to one channel's samples in three
 * pipeline stages, saturating to 24 bits.
 * Assumes offset and gain are steady while samples flow.
 */
`timescale 1ns/1ps
`include "adc_cal_regs_map.svh"

module cal_corrector (
	// Clock and reset.
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	// Correction words.
	input  wire logic [23:0]          offset,
	input  wire logic [23:0]          gain,
	// Samples.
	input  wire adc_cal_pkg::sample_t raw,
	output      adc_cal_pkg::sample_t result
);

	logic               diff_valid;
	logic signed [24:0] diff;
	logic               prod_valid;
	logic signed [49:0] prod;
	logic signed [26:0] scaled;
	logic        [23:0] next_data;

	// Offset is removed before the gain is applied.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			diff_valid <= 1'b0;
			diff       <= '0;
		end else begin
			diff_valid <= raw.valid;
			diff <= $signed({raw.data[23], raw.data})
				- $signed({offset[23], offset});
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			prod_valid <= 1'b0;
			prod       <= '0;
		end else begin
			prod_valid <= diff_valid;
			prod       <= diff * $signed({1'b0, gain});
		end
	end

	assign scaled = prod[`GAIN_FRAC_BITS+26:`GAIN_FRAC_BITS];

	always_comb begin
		next_data = scaled[23:0];
		if (!(&scaled[26:23]) && (|scaled[26:23])) begin
			next_data = scaled[26] ? `SAT_NEG : `SAT_POS;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			result <= '0;
		end else begin
			result.valid <= prod_valid;
			result.data  <= next_data;
		end
	end

	// ****************************************************************
	// Checks.
	// ****************************************************************
	sequence sample_in_s;
		raw.valid;
	endsequence

	sequence offset_removed_s;
		diff == $signed({$past(raw.data[23]), $past(raw.data)})
			- $signed({$past(offset[23]), $past(offset)});
	endsequence

	offset_first_a: assert property (@(posedge ref_clk) disable iff (rst)
		sample_in_s |=> offset_removed_s ##2 result.valid)
		else $error("Corrected sample missing or offset not removed.");

endmodule // cal_corrector

// file: design/adc_channel_cal_config_regs.sv
/*
 * Per-channel input selection and calibration registers of a two
 * channel converter, with the correction datapath they steer.
 * Assumes a plain register port: one-cycle strobes, read data in the
 * cycle after the read strobe, and raw samples on ref_clk.
 */
`timescale 1ns/1ps
`include "adc_cal_regs_map.svh"

// Operation
// - Channel 0 select: 00 pins, 01 shorted, 10 positive test, 11 negative test.
// - Channel 1 select uses the same four-way input encoding.
// - Channel 0 offset bits 23..8 fill the upper offset register.
// - Channel 0 offset bits 7..0 sit in lower offset register bits 15..8.
// - Lower calibration registers read zero in bits 7..0.
// - Channel 0 gain is unsigned; bits 23..8 fill the upper gain register.
// - Channel 0 upper gain resets to 8000h, unity gain.
// - Channel 0 gain bits 7..0 sit in lower gain bits 15..8, reset zero.
// - Channel 1 offset bits 23..8 fill its upper offset register.
// - Channel 0 configuration resets to 0000h, normal input pins.
// - Channel 1 configuration resets to 0000h, normal input pins.
// - Channel 0 upper offset resets to 0000h, zero offset.
// - Channel 1 offset bits 7..0 sit in lower bits 15..8, bits 7..0 read zero.
module adc_channel_cal_config_regs (
	// Clock and reset.
	input  wire logic                    ref_clk,
	input  wire logic                    rst,
	// Register port.
	input  wire adc_cal_pkg::reg_req_t   req,
	output      logic [15:0]             rd_data,
	output      logic                    rd_valid,
	// Input selection and front-end switches.
	output      adc_cal_pkg::input_sel_t ch0_input_select,
	output      adc_cal_pkg::input_sel_t ch1_input_select,
	output      adc_cal_pkg::route_t     ch0_route,
	output      adc_cal_pkg::route_t     ch1_route,
	// Calibration words.
	output      logic [23:0]             ch0_offset,
	output      logic [23:0]             ch0_gain,
	output      logic [23:0]             ch1_offset,
	// Samples.
	input  wire adc_cal_pkg::sample_t    ch0_raw,
	input  wire adc_cal_pkg::sample_t    ch1_raw,
	output      adc_cal_pkg::sample_t    ch0_result,
	output      adc_cal_pkg::sample_t    ch1_result
);

	logic [15:0]          channel0_input_config_keep;
	logic [15:0]          channel1_input_config_keep;
	logic [15:0]          ch0_offset_hi;
	logic [7:0]           ch0_offset_lo;
	logic [15:0]          ch0_gain_hi;
	logic [7:0]           ch0_gain_lo;
	logic [15:0]          ch1_offset_hi;
	logic [7:0]           ch1_offset_lo;
	logic [15:0]          next_rd_data;
	logic [1:0]           wr_sel;
	adc_cal_pkg::input_sel_t sel_arr [2];
	adc_cal_pkg::route_t     route_arr [2];
	adc_cal_pkg::sample_t    raw_arr [2];
	adc_cal_pkg::sample_t    res_arr [2];
	logic [23:0]             off_arr [2];
	logic [23:0]             gain_arr [2];

	assign wr_sel = req.wdata[`SEL_MSB:`SEL_LSB];

	// ****************************************************************
	// Configuration registers.
	// ****************************************************************
	// Reserved bits that software may write are kept and read back;
	// the read-only middle field is masked at write time.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			channel0_input_config_keep     <= `CFG_RESET;
			ch0_input_select <= adc_cal_pkg::SEL_PINS;
		end else if (req.wr && req.addr == `CH0_INPUT_CONFIG_ADDR) begin
			channel0_input_config_keep     <= req.wdata & `CFG_KEEP_MASK;
			ch0_input_select <= adc_cal_pkg::input_sel_t'(wr_sel);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			channel1_input_config_keep     <= `CFG_RESET;
			ch1_input_select <= adc_cal_pkg::SEL_PINS;
		end else if (req.wr && req.addr == `CH1_INPUT_CONFIG_ADDR) begin
			channel1_input_config_keep     <= req.wdata & `CFG_KEEP_MASK;
			ch1_input_select <= adc_cal_pkg::input_sel_t'(wr_sel);
		end
	end

	// ****************************************************************
	// Channel 0 offset.
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ch0_offset_hi <= `CAL_UPPER_RESET;
		end else if (req.wr && req.addr == `CH0_OFFSET_UPPER_ADDR) begin
			ch0_offset_hi <= req.wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ch0_offset_lo <= `CAL_LOWER_RESET;
		end else if (req.wr && req.addr == `CH0_OFFSET_LOWER_ADDR) begin
			ch0_offset_lo <= req.wdata[`LOWER_BYTE_MSB:`LOWER_BYTE_LSB];
		end
	end

	// ****************************************************************
	// Channel 0 gain.
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ch0_gain_hi <= `GAIN_UPPER_RESET;
		end else if (req.wr && req.addr == `CH0_GAIN_UPPER_ADDR) begin
			ch0_gain_hi <= req.wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ch0_gain_lo <= `CAL_LOWER_RESET;
		end else if (req.wr && req.addr == `CH0_GAIN_LOWER_ADDR) begin
			ch0_gain_lo <= req.wdata[`LOWER_BYTE_MSB:`LOWER_BYTE_LSB];
		end
	end

	// ****************************************************************
	// Channel 1 offset.
	// ****************************************************************
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ch1_offset_hi <= `CAL_UPPER_RESET;
		end else if (req.wr && req.addr == `CH1_OFFSET_UPPER_ADDR) begin
			ch1_offset_hi <= req.wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ch1_offset_lo <= `CAL_LOWER_RESET;
		end else if (req.wr && req.addr == `CH1_OFFSET_LOWER_ADDR) begin
			ch1_offset_lo <= req.wdata[`LOWER_BYTE_MSB:`LOWER_BYTE_LSB];
		end
	end

	assign ch0_offset = {ch0_offset_hi, ch0_offset_lo};
	assign ch0_gain   = {ch0_gain_hi, ch0_gain_lo};
	assign ch1_offset = {ch1_offset_hi, ch1_offset_lo};

	// ****************************************************************
	// Read port.
	// ****************************************************************
	always_comb begin
		next_rd_data = `READ_IDLE;
		case (req.addr)
			`CH0_INPUT_CONFIG_ADDR:
				next_rd_data = channel0_input_config_keep | {14'h0000, ch0_input_select};
			`CH0_OFFSET_UPPER_ADDR:
				next_rd_data = ch0_offset_hi;
			`CH0_OFFSET_LOWER_ADDR:
				next_rd_data = {ch0_offset_lo, `RSVD_BYTE_VALUE};
			`CH0_GAIN_UPPER_ADDR:
				next_rd_data = ch0_gain_hi;
			`CH0_GAIN_LOWER_ADDR:
				next_rd_data = {ch0_gain_lo, `RSVD_BYTE_VALUE};
			`CH1_INPUT_CONFIG_ADDR:
				next_rd_data = channel1_input_config_keep | {14'h0000, ch1_input_select};
			`CH1_OFFSET_UPPER_ADDR:
				next_rd_data = ch1_offset_hi;
			`CH1_OFFSET_LOWER_ADDR:
				next_rd_data = {ch1_offset_lo, `RSVD_BYTE_VALUE};
			default:
				next_rd_data = `READ_IDLE;
		endcase
	end

	// Read data stand only in the cycle after the strobe.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rd_data  <= `READ_IDLE;
			rd_valid <= 1'b0;
		end else begin
			rd_data  <= req.rd ? next_rd_data : `READ_IDLE;
			rd_valid <= req.rd;
		end
	end

	// ****************************************************************
	// Per-channel routing and correction.
	// ****************************************************************
	// Channel 1 gain lives outside this bank, so it runs at unity.
	assign sel_arr[0]  = ch0_input_select;
	assign sel_arr[1]  = ch1_input_select;
	assign raw_arr[0]  = ch0_raw;
	assign raw_arr[1]  = ch1_raw;
	assign off_arr[0]  = ch0_offset;
	assign off_arr[1]  = ch1_offset;
	assign gain_arr[0] = ch0_gain;
	assign gain_arr[1] = `GAIN_UNITY;

	for (genvar c = 0; c < 2; c++) begin : g_chan
		input_route u_route (
			.ref_clk (ref_clk),
			.rst     (rst),
			.sel     (sel_arr[c]),
			.route   (route_arr[c])
		);
		cal_corrector u_corr (
			.ref_clk (ref_clk),
			.rst     (rst),
			.offset  (off_arr[c]),
			.gain    (gain_arr[c]),
			.raw     (raw_arr[c]),
			.result  (res_arr[c])
		);
	end

	assign ch0_route  = route_arr[0];
	assign ch1_route  = route_arr[1];
	assign ch0_result = res_arr[0];
	assign ch1_result = res_arr[1];

	// ****************************************************************
	// Checks.
	// ****************************************************************
	sequence wr_to_s(logic [7:0] a);
		req.wr && req.addr == a;
	endsequence

	gain_reset_a: assert property (@(posedge ref_clk)
		rst |=> ch0_gain == `GAIN_UNITY)
		else $error("Gain word is not unity after reset.");

	cfg0_reset_a: assert property (@(posedge ref_clk)
		rst |=> ch0_input_select == adc_cal_pkg::SEL_PINS
			&& channel0_input_config_keep == `CFG_RESET)
		else $error("Channel 0 configuration not cleared by reset.");

	cfg1_reset_a: assert property (@(posedge ref_clk)
		rst |=> ch1_input_select == adc_cal_pkg::SEL_PINS
			&& channel1_input_config_keep == `CFG_RESET)
		else $error("Channel 1 configuration not cleared by reset.");

	offset_reset_a: assert property (@(posedge ref_clk)
		rst |=> ch0_offset == 24'h000000)
		else $error("Channel 0 offset not zero after reset.");

	offset_upper_a: assert property (@(posedge ref_clk) disable iff (rst)
		wr_to_s(`CH0_OFFSET_UPPER_ADDR) |=> ch0_offset[23:8] == $past(req.wdata))
		else $error("Channel 0 upper offset not stored.");

	offset_lower_a: assert property (@(posedge ref_clk) disable iff (rst)
		wr_to_s(`CH0_OFFSET_LOWER_ADDR)
			|=> ch0_offset[7:0] == $past(req.wdata[15:8]))
		else $error("Channel 0 lower offset byte not stored.");

	gain_upper_a: assert property (@(posedge ref_clk) disable iff (rst)
		wr_to_s(`CH0_GAIN_UPPER_ADDR) |=> ch0_gain[23:8] == $past(req.wdata))
		else $error("Channel 0 upper gain not stored.");

	gain_lower_a: assert property (@(posedge ref_clk) disable iff (rst)
		wr_to_s(`CH0_GAIN_LOWER_ADDR)
			|=> ch0_gain[7:0] == $past(req.wdata[15:8]))
		else $error("Channel 0 lower gain byte not stored.");

	ch1_upper_a: assert property (@(posedge ref_clk) disable iff (rst)
		wr_to_s(`CH1_OFFSET_UPPER_ADDR) |=> ch1_offset[23:8] == $past(req.wdata))
		else $error("Channel 1 upper offset not stored.");

	ch1_readback_a: assert property (@(posedge ref_clk) disable iff (rst)
		wr_to_s(`CH1_OFFSET_LOWER_ADDR) ##1
			(req.rd && req.addr == `CH1_OFFSET_LOWER_ADDR && !req.wr)
			|=> rd_data == {$past(req.wdata[15:8], 2), 8'h00})
		else $error("Channel 1 lower offset read back wrong.");

	lower_rsvd_a: assert property (@(posedge ref_clk) disable iff (rst)
		req.rd && (req.addr == `CH0_OFFSET_LOWER_ADDR
			|| req.addr == `CH0_GAIN_LOWER_ADDR)
			|=> rd_valid && rd_data[7:0] == 8'h00)
		else $error("Reserved low byte did not read zero.");

	cfg_rsvd_a: assert property (@(posedge ref_clk) disable iff (rst)
		req.rd && (req.addr == `CH0_INPUT_CONFIG_ADDR
			|| req.addr == `CH1_INPUT_CONFIG_ADDR)
			|=> rd_data[5:3] == 3'h0)
		else $error("Read-only configuration bits not zero.");

	sel_route_a: assert property (@(posedge ref_clk) disable iff (rst)
		req.wr && req.addr == `CH0_INPUT_CONFIG_ADDR
			&& req.wdata[1:0] == 2'h0
			|=> ##1 ch0_route.pins_connected)
		else $error("Channel 0 pins not connected after select 00.");

endmodule // adc_channel_cal_config_regs

// file: tb/adc_channel_cal_config_regs_tb_top.sv
/*
 * Self-checking bench for the channel configuration and calibration
 * register bank: reset values, select encoding, word packing, reserved
 * bits and the corrected sample path.
 * Assumes the design, its package and its register map header.
 */
`timescale 1ns/1ps
`include "adc_cal_regs_map.svh"

module adc_channel_cal_config_regs_tb_top;

	logic                    ref_clk = 1'b0;
	logic                    rst     = 1'b1;
	adc_cal_pkg::reg_req_t   req     = '0;
	logic [15:0]             rd_data;
	logic                    rd_valid;
	adc_cal_pkg::input_sel_t ch0_input_select;
	adc_cal_pkg::input_sel_t ch1_input_select;
	adc_cal_pkg::route_t     ch0_route;
	adc_cal_pkg::route_t     ch1_route;
	logic [23:0]             ch0_offset;
	logic [23:0]             ch0_gain;
	logic [23:0]             ch1_offset;
	adc_cal_pkg::sample_t    ch0_raw = '0;
	adc_cal_pkg::sample_t    ch1_raw = '0;
	adc_cal_pkg::sample_t    ch0_result;
	adc_cal_pkg::sample_t    ch1_result;
	int                      fail_count  = 0;
	int                      check_count = 0;
	int                      cycles      = 0;

	always #25 ref_clk = ~ref_clk;

	adc_channel_cal_config_regs i_dut (
		.ref_clk          (ref_clk),
		.rst              (rst),
		.req              (req),
		.rd_data          (rd_data),
		.rd_valid         (rd_valid),
		.ch0_input_select (ch0_input_select),
		.ch1_input_select (ch1_input_select),
		.ch0_route        (ch0_route),
		.ch1_route        (ch1_route),
		.ch0_offset       (ch0_offset),
		.ch0_gain         (ch0_gain),
		.ch1_offset       (ch1_offset),
		.ch0_raw          (ch0_raw),
		.ch1_raw          (ch1_raw),
		.ch0_result       (ch0_result),
		.ch1_result       (ch1_result)
	);

	// ****************************************************************
	// Bus cycles and comparison.
	// ****************************************************************
	task automatic check(input bit ok, input string msg);
		check_count++;
		if (!ok) begin
			fail_count++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		req.wr <= 1'b0;
	endtask

	// Read data must stand in the cycle after the strobe and only there.
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		req.rd <= 1'b0;
		#1;
		check(rd_valid === 1'b1 && rd_data === exp, "read data");
		@(posedge ref_clk);
		#1;
		check(rd_valid === 1'b0, "read valid longer than one cycle");
	endtask

	// Write then read the same register with no idle cycle between.
	task automatic wr_rd(input logic [7:0] a, input logic [15:0] d,
			input logic [15:0] exp);
		@(posedge ref_clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		req.rd <= 1'b0;
		#1;
		check(rd_valid === 1'b1 && rd_data === exp, "write then read");
	endtask

	task automatic do_reset();
		rst <= 1'b1;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
	endtask

	// Offset is taken off before the gain scales the difference.
	function automatic logic [23:0] corr(input logic [23:0] raw,
			input logic [23:0] off, input logic [23:0] gain);
		logic signed [25:0] d;
		logic signed [50:0] p;
		d = $signed({raw[23], raw}) - $signed({off[23], off});
		p = d * $signed({1'b0, gain});
		p = p >>> 23;
		if (p > 51'sd8388607)
			return 24'h7FFFFF;
		if (p < -51'sd8388608)
			return 24'h800000;
		return p[23:0];
	endfunction

	task automatic sample(input bit ch, input logic [23:0] raw,
			input logic [23:0] exp);
		@(posedge ref_clk);
		if (ch)
			ch1_raw <= '{valid: 1'b1, data: raw};
		else
			ch0_raw <= '{valid: 1'b1, data: raw};
		@(posedge ref_clk);
		ch0_raw.valid <= 1'b0;
		ch1_raw.valid <= 1'b0;
		@(posedge ref_clk);
		#1;
		check((ch ? ch1_result.valid : ch0_result.valid) === 1'b0,
			"result early");
		@(posedge ref_clk);
		#1;
		check((ch ? ch1_result : ch0_result) === {1'b1, exp},
			"corrected sample");
	endtask

	// ****************************************************************
	// Scenarios.
	// ****************************************************************
	task automatic test_reset_values();
		check(ch0_gain === 24'h800000, "gain reset");
		check(ch0_offset === 24'h0 && ch1_offset === 24'h0, "offsets");
		check(ch0_route === 4'h8 && ch1_route === 4'h8, "route reset");
		rd(8'h09, 16'h0000);
		rd(8'h0A, 16'h0000);
		rd(8'h0B, 16'h0000);
		rd(8'h0C, 16'h8000);
		rd(8'h0D, 16'h0000);
		rd(8'h0E, 16'h0000);
		rd(8'h0F, 16'h0000);
		rd(8'h10, 16'h0000);
		$display("test reset values done");
	endtask

	task automatic test_select();
		for (int i = 0; i < 4; i++) begin
			wr(8'h09, 16'(i));
			wr(8'h0E, 16'(3 - i));
			#1;
			check(ch0_input_select === 2'(i), "ch0 select");
			check(ch1_input_select === 2'(3 - i), "ch1 select");
			@(posedge ref_clk);
			#1;
			check(ch0_route === (4'h8 >> i), "ch0 route");
			check(ch1_route === (4'h8 >> (3 - i)), "ch1 route");
			rd(8'h09, 16'(i));
		end
		$display("test select done");
	endtask

	task automatic test_reserved();
		wr(8'h09, 16'hFFFF);
		rd(8'h09, 16'hFFC7);
		wr(8'h0E, 16'hFFFF);
		rd(8'h0E, 16'hFFC7);
		wr(8'h09, 16'h0000);
		wr(8'h0E, 16'h0000);
		rd(8'h11, 16'h0000);
		rd(8'h08, 16'h0000);
		$display("test reserved done");
	endtask

	task automatic test_words();
		wr(8'h0A, 16'hA5C3);
		wr(8'h0B, 16'h7EFF);
		wr(8'h0C, 16'h1234);
		wr(8'h0D, 16'hABFF);
		wr(8'h0F, 16'hFEDC);
		wr(8'h10, 16'h55AA);
		#1;
		check(ch0_offset === 24'hA5C37E, "ch0 offset word");
		check(ch0_gain === 24'h1234AB, "ch0 gain word");
		check(ch1_offset === 24'hFEDC55, "ch1 offset word");
		rd(8'h0A, 16'hA5C3);
		rd(8'h0B, 16'h7E00);
		rd(8'h0C, 16'h1234);
		rd(8'h0D, 16'hAB00);
		rd(8'h0F, 16'hFEDC);
		rd(8'h10, 16'h5500);
		wr_rd(8'h10, 16'h33CC, 16'h3300);
		$display("test words done");
	endtask

	task automatic test_datapath();
		wr(8'h0A, 16'h0001);
		wr(8'h0B, 16'h0000);
		wr(8'h0C, 16'hC000);
		wr(8'h0D, 16'h0000);
		wr(8'h0F, 16'hFFFF);
		wr(8'h10, 16'h0000);
		sample(1'b0, 24'h001100, 24'h001800);
		sample(1'b0, 24'h7FFFFF,
			corr(24'h7FFFFF, 24'h000100, 24'hC00000));
		sample(1'b0, 24'h800000,
			corr(24'h800000, 24'h000100, 24'hC00000));
		sample(1'b1, 24'h000010,
			corr(24'h000010, 24'hFFFF00, 24'h800000));
		$display("test datapath done");
	endtask

	task automatic test_second_reset();
		@(posedge ref_clk);
		do_reset();
		rd(8'h0C, 16'h8000);
		rd(8'h0F, 16'h0000);
		rd(8'h09, 16'h0000);
		$display("test second reset done");
	endtask

	// ****************************************************************
	// Run control.
	// ****************************************************************
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			$display("unexpected at %0t: run timed out", $time);
			finish_test();
		end
	end

	initial begin
		do_reset();
		#1;
		test_reset_values();
		test_select();
		test_reserved();
		test_words();
		test_datapath();
		test_second_reset();
		finish_test();
	end

endmodule // adc_channel_cal_config_regs_tb_top
